// ---- logic/torque_limit_pkg.sv ----
package torque_limit_pkg;

   // ********************
   // Register map
   // ********************
   localparam int          ADDR_W            = 10;
   localparam int          DATA_W            = 32;
   localparam logic [9:0]  OFS_REF_USE       = 10'h000;
   localparam logic [9:0]  OFS_CTRL_METHOD   = 10'h004;
   localparam logic [9:0]  OFS_LIMIT_GAIN    = 10'h008;
   localparam logic [9:0]  OFS_FWD_LIMIT     = 10'h00c;
   localparam logic [9:0]  OFS_REV_LIMIT     = 10'h010;
   localparam logic [9:0]  OFS_ROUTING_MODE  = 10'h014;
   localparam logic [9:0]  OFS_ALLOCATION    = 10'h018;
   localparam logic [9:0]  OFS_JOG_RATE      = 10'h01c;
   localparam logic [9:0]  OFS_JOG_CMD       = 10'h100;
   localparam logic [9:0]  OFS_MON_LIMITS    = 10'h200;
   localparam logic [9:0]  OFS_MON_POSITION  = 10'h204;
   localparam logic [9:0]  OFS_MON_FUNCS     = 10'h208;

   // ********************
   // Field encodings and reset values
   // ********************
   localparam logic [1:0]  USE_NONE          = 2'h0;
   localparam logic [1:0]  USE_EXT_LIMIT     = 2'h1;
   localparam logic [1:0]  USE_FEED_FWD      = 2'h2;
   localparam logic [1:0]  USE_GATED_LIMIT   = 2'h3;
   localparam logic [3:0]  CM_POS_NO_INHIBIT = 4'h1;
   localparam logic [3:0]  CM_TORQUE         = 4'h2;
   localparam logic [3:0]  CM_POS_INHIBIT    = 4'hb;
   localparam logic [3:0]  RST_CTRL_METHOD   = 4'h0;
   localparam logic [1:0]  RST_REF_USE       = 2'h0;
   localparam logic [6:0]  GAIN_MIN          = 7'h0a;
   localparam logic [6:0]  GAIN_MAX          = 7'h64;
   localparam logic [6:0]  RST_LIMIT_GAIN    = 7'h1e;
   localparam logic [9:0]  EXT_LIMIT_MAX     = 10'h320;
   localparam logic [9:0]  RST_EXT_LIMIT     = 10'h064;
   localparam logic [9:0]  RATED_PCT         = 10'h064;
   localparam logic [13:0] JOG_RATE_MAX      = 14'h2710;
   localparam logic [13:0] RST_JOG_RATE      = 14'h01f4;
   localparam logic [0:0]  RST_ROUTING_MODE  = 1'h0;
   localparam int          NUM_SEQ           = 7;
   // Default allocation: function k from input k, nibble k
   localparam logic [27:0] RST_ALLOCATION    = 28'h6543210;
   localparam logic [3:0]  ALLOC_ALWAYS      = 4'h7;
   localparam logic [3:0]  ALLOC_NEVER       = 4'h8;
   localparam logic [3:0]  ALLOC_REVERSED    = 4'h9;
   // Analog input LSB is 10 mV, gain LSB is 100 mV per rated torque
   localparam logic [4:0]  ANALOG_PER_GAIN   = 5'd10;

   // ********************
   // Decoded sequence functions, active high
   // ********************
   typedef struct packed {
      logic rev_limit_request;
      logic fwd_limit_request;
      logic alarm_clear_request;
      logic reverse_travel_block;
      logic forward_travel_block;
      logic proportional_select_in;
      logic servo_on;
   } seq_func_t;

endpackage

// ---- logic/torque_limit_inhibit_input_routing.sv ----
// Function
// R1: Use field 3 makes the analog input a limit gated by limit requests.
// R2: Use field 0 unused, 1 always-on external limit, 2 torque feed-forward.
// R3: Forward request low caps forward torque at smaller of setting and analog.
// R4: Reverse request low caps reverse torque at smaller of setting and analog.
// R5: A high request applies no analog limit in that direction.
// R6: Gated analog limiting and feed-forward are never active together.
// R7: Gated analog limiting is unavailable in torque control mode.
// R8: Limit input gain accepts 10 to 100 in 0.1 V units, resets to 30.
// R9: Analog magnitude is used; derived limits above rated clamp to 100%.
// R10: Forward and reverse limit settings accept 0 to 800, reset to 100.
// R11: Inhibit asserted in position mode stops pulse counting, locks motor.
// R12: Control method 1 always counts; B lets the inhibit input gate counting.
// R13: Inhibit enabled but deasserted counts reference pulses normally.
// R14: Jog speed accepts 0 to 10000, resets to 500, capped at motor maximum.
// R15: Default inputs 0 to 6 map to the seven sequence functions in order.
// R16: Routing mode 0 fixed assignment, 1 free assignment, resets to 0.
// R17: Routing mode 0 switches starred input functions by control method.
// R18: Settings form three groups: settings, auxiliary functions, monitors.
// R19: Limits recomputed every cycle, effective on the next cycle.
`timescale 1ns/1ps
`default_nettype none

module torque_limit_inhibit_input_routing
   import torque_limit_pkg::*;
#(
   parameter int          ANALOG_W      = 16,
   parameter logic [13:0] MOTOR_MAX_RPM = 14'h2710
) (
   input  wire logic                       ref_clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic [ADDR_W-1:0]          addr_i,
   input  wire logic [DATA_W-1:0]          wdata_i,
   input  wire logic                       wr_i,
   input  wire logic                       rd_i,
   output logic      [DATA_W-1:0]          rdata_o,
   input  wire logic [NUM_SEQ-1:0]         seq_input_n_i,
   input  wire logic                       ref_pulse_i,
   input  wire logic                       ref_dir_i,
   input  wire logic signed [ANALOG_W-1:0] analog_torque_i,
   output logic      [9:0]                 fwd_torque_limit_o,
   output logic      [9:0]                 rev_torque_limit_o,
   output logic                            torque_ff_enable_o,
   output logic                            torque_ref_enable_o,
   output logic                            pulse_count_enable_o,
   output logic                            position_lock_o,
   output logic      [13:0]                jog_speed_o,
   output logic                            jog_fwd_o,
   output logic                            jog_rev_o,
   output seq_func_t                       seq_func_o
);

   // ********************
   // Settings
   // ********************
   logic [1:0]          ref_use_r;
   logic [3:0]          ctrl_method_r;
   logic [6:0]          limit_gain_r;
   logic [9:0]          fwd_limit_r;
   logic [9:0]          rev_limit_r;
   logic                routing_mode_r;
   logic [27:0]         allocation_r;
   logic [13:0]         jog_rate_r;
   logic [1:0]          jog_cmd_r;
   logic [DATA_W-1:0]   rdata_r;

   wire        wr_ref_use  = wr_i && (addr_i == OFS_REF_USE);
   wire        wr_ctrl     = wr_i && (addr_i == OFS_CTRL_METHOD);
   wire        wr_gain     = wr_i && (addr_i == OFS_LIMIT_GAIN);
   wire        wr_fwd      = wr_i && (addr_i == OFS_FWD_LIMIT);
   wire        wr_rev      = wr_i && (addr_i == OFS_REV_LIMIT);
   wire        wr_routing  = wr_i && (addr_i == OFS_ROUTING_MODE);
   wire        wr_alloc    = wr_i && (addr_i == OFS_ALLOCATION);
   wire        wr_jog_rate = wr_i && (addr_i == OFS_JOG_RATE);
   wire        wr_jog_cmd  = wr_i && (addr_i == OFS_JOG_CMD);

   // Out-of-range writes are dropped so the setting never holds an illegal value
   // R8: gain range check
   wire        gain_ok     = (wdata_i[31:7] == 25'h0) && (wdata_i[6:0] >= GAIN_MIN)
                             && (wdata_i[6:0] <= GAIN_MAX);
   // R10: limit range check
   wire        ext_ok      = (wdata_i[31:10] == 22'h0) && (wdata_i[9:0] <= EXT_LIMIT_MAX);
   // R14: jog range check
   wire        jog_ok      = (wdata_i[31:14] == 18'h0) && (wdata_i[13:0] <= JOG_RATE_MAX);

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ref_use_r      <= RST_REF_USE;
         ctrl_method_r  <= RST_CTRL_METHOD;
         limit_gain_r   <= RST_LIMIT_GAIN;
         fwd_limit_r    <= RST_EXT_LIMIT;
         rev_limit_r    <= RST_EXT_LIMIT;
         routing_mode_r <= RST_ROUTING_MODE;
         allocation_r   <= RST_ALLOCATION;
         jog_rate_r     <= RST_JOG_RATE;
         jog_cmd_r      <= 2'h0;
      end else begin
         if (wr_ref_use) begin
            ref_use_r <= wdata_i[1:0];
         end
         if (wr_ctrl) begin
            ctrl_method_r <= wdata_i[3:0];
         end
         if (wr_gain && gain_ok) begin
            limit_gain_r <= wdata_i[6:0];
         end
         if (wr_fwd && ext_ok) begin
            fwd_limit_r <= wdata_i[9:0];
         end
         if (wr_rev && ext_ok) begin
            rev_limit_r <= wdata_i[9:0];
         end
         // R16: routing mode store
         if (wr_routing) begin
            routing_mode_r <= wdata_i[0];
         end
         if (wr_alloc) begin
            allocation_r <= wdata_i[27:0];
         end
         if (wr_jog_rate && jog_ok) begin
            jog_rate_r <= wdata_i[13:0];
         end
         // Both directions at once is ambiguous, so that write stops jog
         if (wr_jog_cmd) begin
            jog_cmd_r <= (wdata_i[1:0] == 2'h3) ? 2'h0 : wdata_i[1:0];
         end
      end
   end

   // ********************
   // Input synchronisers
   // ********************
   logic [NUM_SEQ-1:0] seq_meta_r;
   logic [NUM_SEQ-1:0] seq_sync_r;
   logic [1:0]         pulse_meta_r;
   logic [1:0]         pulse_sync_r;
   logic               pulse_prev_r;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         seq_meta_r   <= {NUM_SEQ{1'b1}};
         seq_sync_r   <= {NUM_SEQ{1'b1}};
         pulse_meta_r <= 2'h0;
         pulse_sync_r <= 2'h0;
         pulse_prev_r <= 1'b0;
      end else begin
         seq_meta_r   <= seq_input_n_i;
         seq_sync_r   <= seq_meta_r;
         pulse_meta_r <= {ref_dir_i, ref_pulse_i};
         pulse_sync_r <= pulse_meta_r;
         pulse_prev_r <= pulse_sync_r[0];
      end
   end

   // ********************
   // Sequence input routing
   // ********************
   logic [NUM_SEQ-1:0] free_func;
   logic [NUM_SEQ-1:0] fixed_func;
   logic [NUM_SEQ-1:0] func_sel;

   // Inputs are active low; free codes 9..F take the input reversed
   genvar k;
   generate
      for (k = 0; k < NUM_SEQ; k++) begin : g_route
         wire [3:0] code = allocation_r[4*k +: 4];
         wire [2:0] idx  = (code >= ALLOC_REVERSED) ? 3'(code - ALLOC_REVERSED) : code[2:0];
         wire       pin  = (idx < 3'(NUM_SEQ)) ? seq_sync_r[idx] : 1'b1;
         assign free_func[k] = (code < ALLOC_ALWAYS)   ? !pin :
                               (code == ALLOC_ALWAYS)  ? 1'b1 :
                               (code == ALLOC_NEVER)   ? 1'b0 :
                               (idx < 3'(NUM_SEQ))     ? pin  : 1'b0;
         // R15: fixed default order
         assign fixed_func[k] = !seq_sync_r[k];
      end
   endgenerate

   // R16: fixed or free selection
   assign func_sel = routing_mode_r ? free_func : fixed_func;

   wire seq_func_t funcs = seq_func_t'(func_sel);

   // R17: starred input switches to inhibit under method B in fixed mode
   wire inhibit_enabled = (ctrl_method_r == CM_POS_INHIBIT);
   wire inhibit_active  = inhibit_enabled && funcs.proportional_select_in;
   wire prop_active     = funcs.proportional_select_in
                          && !(inhibit_enabled && !routing_mode_r);

   // ********************
   // Analog terminal use
   // ********************
   wire torque_mode = (ctrl_method_r == CM_TORQUE);
   // R2: always-on external limit
   wire ext_always  = (ref_use_r == USE_EXT_LIMIT) && !torque_mode;
   // R6: feed-forward only when use field selects it
   wire ff_on       = (ref_use_r == USE_FEED_FWD) && !torque_mode;
   // R7: gated limit disabled in torque mode
   wire gated_on    = (ref_use_r == USE_GATED_LIMIT) && !torque_mode;

   // ********************
   // Analog limit derivation
   // ********************
   // R9: magnitude of the analog value
   wire [ANALOG_W-1:0]   analog_mag = analog_torque_i[ANALOG_W-1]
                                      ? ANALOG_W'(-analog_torque_i)
                                      : ANALOG_W'(analog_torque_i);
   wire [ANALOG_W+4:0]   scaled     = (ANALOG_W+5)'(analog_mag) * (ANALOG_W+5)'(ANALOG_PER_GAIN);
   // Gain never falls below its minimum, so the divisor is never zero
   wire [ANALOG_W+4:0]   pct_raw    = scaled / (ANALOG_W+5)'(limit_gain_r);
   // R9: clamp to rated torque
   wire [9:0]            analog_pct = (pct_raw > (ANALOG_W+5)'(RATED_PCT)) ? RATED_PCT
                                      : pct_raw[9:0];

   // R3: forward minimum
   wire [9:0] fwd_min = (fwd_limit_r < analog_pct) ? fwd_limit_r : analog_pct;
   // R4: reverse minimum
   wire [9:0] rev_min = (rev_limit_r < analog_pct) ? rev_limit_r : analog_pct;

   // Without an analog limit the stored setting is still the ceiling
   // R1: gating by requests
   wire fwd_apply = ext_always || (gated_on && funcs.fwd_limit_request);
   wire rev_apply = ext_always || (gated_on && funcs.rev_limit_request);
   // R5: deasserted request keeps the stored setting only, unless use field 1 applies the analog limit always
   wire [9:0] fwd_nxt = fwd_apply ? fwd_min : fwd_limit_r;
   wire [9:0] rev_nxt = rev_apply ? rev_min : rev_limit_r;

   // ********************
   // Reference pulse counting
   // ********************
   logic [31:0] position_r;
   logic [9:0]  fwd_out_r;
   logic [9:0]  rev_out_r;
   logic        ff_r;
   logic        tref_r;
   logic        count_en_r;
   logic        lock_r;
   logic [13:0] jog_speed_r;
   seq_func_t   func_r;

   // R11: inhibit stops counting and locks
   wire count_en  = !inhibit_active;
   wire pulse_rise = pulse_sync_r[0] && !pulse_prev_r;
   // R14: cap at motor maximum
   wire [13:0] jog_nxt = (jog_rate_r > MOTOR_MAX_RPM) ? MOTOR_MAX_RPM : jog_rate_r;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         position_r  <= 32'h0;
         fwd_out_r   <= RST_EXT_LIMIT;
         rev_out_r   <= RST_EXT_LIMIT;
         ff_r        <= 1'b0;
         tref_r      <= 1'b0;
         count_en_r  <= 1'b1;
         lock_r      <= 1'b0;
         jog_speed_r <= RST_JOG_RATE;
         func_r      <= '0;
      end else begin
         // R12: method 1 never inhibits; B gates
         // R13: deasserted inhibit counts normally
         if (pulse_rise && count_en) begin
            position_r <= pulse_sync_r[1] ? position_r - 32'h1 : position_r + 32'h1;
         end
         // R19: limits registered every cycle
         fwd_out_r   <= fwd_nxt;
         rev_out_r   <= rev_nxt;
         ff_r        <= ff_on;
         tref_r      <= torque_mode;
         count_en_r  <= count_en;
         lock_r      <= inhibit_active;
         jog_speed_r <= jog_nxt;
         func_r      <= seq_func_t'({func_sel[6:2], prop_active, func_sel[0]});
      end
   end

   // ********************
   // Read path
   // ********************
   logic [DATA_W-1:0] rd_mux;

   // R18: three register groups by address
   always_comb begin
      rd_mux = '0;
      case (addr_i)
         OFS_REF_USE:      rd_mux = {30'h0, ref_use_r};
         OFS_CTRL_METHOD:  rd_mux = {28'h0, ctrl_method_r};
         OFS_LIMIT_GAIN:   rd_mux = {25'h0, limit_gain_r};
         OFS_FWD_LIMIT:    rd_mux = {22'h0, fwd_limit_r};
         OFS_REV_LIMIT:    rd_mux = {22'h0, rev_limit_r};
         OFS_ROUTING_MODE: rd_mux = {31'h0, routing_mode_r};
         OFS_ALLOCATION:   rd_mux = {4'h0, allocation_r};
         OFS_JOG_RATE:     rd_mux = {18'h0, jog_rate_r};
         OFS_JOG_CMD:      rd_mux = {30'h0, jog_cmd_r};
         OFS_MON_LIMITS:   rd_mux = {6'h0, rev_out_r, 6'h0, fwd_out_r};
         OFS_MON_POSITION: rd_mux = position_r;
         OFS_MON_FUNCS:    rd_mux = {22'h0, lock_r, count_en_r, 1'b0, func_r};
         default:          rd_mux = '0;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= rd_i ? rd_mux : '0;
      end
   end

   // ********************
   // Outputs
   // ********************
   assign rdata_o              = rdata_r;
   assign fwd_torque_limit_o   = fwd_out_r;
   assign rev_torque_limit_o   = rev_out_r;
   assign torque_ff_enable_o   = ff_r;
   assign torque_ref_enable_o  = tref_r;
   assign pulse_count_enable_o = count_en_r;
   assign position_lock_o      = lock_r;
   assign jog_speed_o          = jog_speed_r;
   assign jog_fwd_o            = jog_cmd_r[0];
   assign jog_rev_o            = jog_cmd_r[1];
   assign seq_func_o           = func_r;

endmodule

`default_nettype wire

// ---- tb/torque_limit_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************
// Port checks, mirroring accepted setting writes
// ********************
module torque_limit_asserts
   import torque_limit_pkg::*;
#(
   parameter logic [13:0] MOTOR_MAX_RPM = 14'h2710
) (
   input wire logic              ref_clk_i,
   input wire logic              rst_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic              wr_i,
   input wire logic              rd_i,
   input wire logic [DATA_W-1:0] rdata_o,
   input wire logic [9:0]        fwd_torque_limit_o,
   input wire logic [9:0]        rev_torque_limit_o,
   input wire logic              torque_ff_enable_o,
   input wire logic              torque_ref_enable_o,
   input wire logic              pulse_count_enable_o,
   input wire logic              position_lock_o,
   input wire logic [13:0]       jog_speed_o
);
   logic [1:0] use_r;
   logic [6:0] gain_r;
   logic [9:0] fwd_r, rev_r;
   logic       wr_use, wr_gain, wr_fwd, wr_rev;
   // Out-of-range data is dropped, so the mirror drops it too
   assign wr_use  = wr_i && addr_i == OFS_REF_USE;
   assign wr_gain = wr_i && addr_i == OFS_LIMIT_GAIN && wdata_i >= {25'h0, GAIN_MIN}
                    && wdata_i <= {25'h0, GAIN_MAX};
   assign wr_fwd  = wr_i && addr_i == OFS_FWD_LIMIT && wdata_i <= {22'h0, EXT_LIMIT_MAX};
   assign wr_rev  = wr_i && addr_i == OFS_REV_LIMIT && wdata_i <= {22'h0, EXT_LIMIT_MAX};
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         use_r  <= RST_REF_USE;
         gain_r <= RST_LIMIT_GAIN;
         fwd_r  <= RST_EXT_LIMIT;
         rev_r  <= RST_EXT_LIMIT;
      end else begin
         if (wr_use) use_r <= wdata_i[1:0];
         if (wr_gain) gain_r <= wdata_i[6:0];
         if (wr_fwd) fwd_r <= wdata_i[9:0];
         if (wr_rev) rev_r <= wdata_i[9:0];
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == '0)
      else $error("read data not zero outside read answer");
   AST_GAIN_READBACK: assert property ($past(rd_i) && $past(addr_i) == OFS_LIMIT_GAIN
      |-> rdata_o == {25'h0, $past(gain_r)}) else $error("gain readback wrong");
   AST_FWD_READBACK: assert property ($past(rd_i) && $past(addr_i) == OFS_FWD_LIMIT
      |-> rdata_o == {22'h0, $past(fwd_r)}) else $error("forward setting readback wrong");
   AST_FWD_CAP: assert property (fwd_torque_limit_o <= $past(fwd_r))
      else $error("forward limit above setting");
   AST_REV_CAP: assert property (rev_torque_limit_o <= $past(rev_r))
      else $error("reverse limit above setting");
   AST_UNUSED_NO_LIMIT: assert property ($past(use_r) == USE_NONE
      |-> fwd_torque_limit_o == $past(fwd_r) && rev_torque_limit_o == $past(rev_r))
      else $error("analog limit applied while terminal unused");
   AST_TORQUE_MODE: assert property (torque_ref_enable_o
      |-> fwd_torque_limit_o == $past(fwd_r) && rev_torque_limit_o == $past(rev_r))
      else $error("analog limit applied in torque mode");
   AST_FF_EXCL: assert property (torque_ff_enable_o
      |-> !torque_ref_enable_o && $past(use_r) == USE_FEED_FWD)
      else $error("feed-forward enabled wrongly");
   AST_LOCK_NO_COUNT: assert property (position_lock_o |-> !pulse_count_enable_o)
      else $error("pulses counted while locked");
   AST_JOG_CAP: assert property (jog_speed_o <= MOTOR_MAX_RPM && jog_speed_o <= JOG_RATE_MAX)
      else $error("jog speed above maximum");
endmodule
bind torque_limit_inhibit_input_routing torque_limit_asserts #(.MOTOR_MAX_RPM(MOTOR_MAX_RPM))
   u_torque_limit_asserts (.*);
`default_nettype wire

// ---- tb/host_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********************
// Host controller: sequence pins and reference pulse train
// ********************
module host_ctrl_model (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic [6:0] func_on_i,
   input  wire logic       go_i,
   input  wire logic [7:0] count_i,
   input  wire logic       dir_i,
   output logic      [6:0] seq_input_n_o,
   output logic            ref_pulse_o,
   output logic            ref_dir_o,
   output logic            busy_o
);
   logic [9:0] left_r;
   // Two cycles high, two low, so each pulse survives the pin synchroniser
   assign ref_pulse_o = left_r[1];
   assign busy_o      = left_r != '0;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         left_r        <= '0;
         ref_dir_o     <= 1'b0;
         seq_input_n_o <= 7'h7f;
      end else begin
         seq_input_n_o <= ~func_on_i;
         if (go_i) ref_dir_o <= dir_i;
         left_r <= go_i ? {count_i, 2'b00} : (busy_o ? left_r - 10'h1 : left_r);
      end
   end
endmodule
`default_nettype wire

// ---- tb/torque_limit_inhibit_input_routing_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module torque_limit_inhibit_input_routing_tb_top
   import torque_limit_pkg::*;
;
   localparam logic [13:0] MAX_RPM = 14'h1770;
   logic              ref_clk_i = 1'b0;
   logic              rst_n_i   = 1'b0;
   logic [9:0]        addr      = '0;
   logic [31:0]       wdata     = '0;
   logic              wr        = 1'b0;
   logic              rd        = 1'b0;
   logic signed [15:0] analog   = '0;
   logic [6:0]        func_on   = '0;
   logic              go        = 1'b0;
   logic [7:0]        cnt       = '0;
   logic              dir       = 1'b0;
   logic [31:0]       rdata, v;
   logic [6:0]        seq_n;
   logic              pulse, pdir, busy, ff, tref, cnt_en, lock, jfwd, jrev;
   logic [9:0]        fwd, rev;
   logic [13:0]       jog;
   seq_func_t         func;
   integer            seed      = 32'h7fba9e02;
   int                n_errors  = 0;
   int                compares  = 0;
   logic              rmode     = 1'b0;
   logic [27:0]       ralloc    = RST_ALLOCATION;
   logic [3:0]        ms[4]     = '{4'h0, CM_POS_NO_INHIBIT, CM_POS_INHIBIT, CM_TORQUE};
   logic [9:0]        ofs[10]   = '{OFS_REF_USE, OFS_CTRL_METHOD, OFS_LIMIT_GAIN, OFS_FWD_LIMIT,
      OFS_REV_LIMIT, OFS_ROUTING_MODE, OFS_ALLOCATION, OFS_JOG_RATE, OFS_JOG_CMD, 10'h300};
   logic [31:0]       rv[10]    = '{32'h0, 32'h0, 32'd30, 32'd100, 32'd100, 32'h0,
      32'h6543210, 32'd500, 32'h0, 32'h0};
   logic [31:0]       bad[8]    = '{32'h4, 32'h10, 32'd101, 32'd801, 32'd801, 32'h2,
      32'h1654_3210, 32'd10001};
   always #10 ref_clk_i = ~ref_clk_i;
   torque_limit_inhibit_input_routing #(.ANALOG_W(16), .MOTOR_MAX_RPM(MAX_RPM))
   u_torque_limit_inhibit_input_routing (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .seq_input_n_i(seq_n), .ref_pulse_i(pulse),
      .ref_dir_i(pdir), .analog_torque_i(analog), .fwd_torque_limit_o(fwd),
      .rev_torque_limit_o(rev), .torque_ff_enable_o(ff), .torque_ref_enable_o(tref),
      .pulse_count_enable_o(cnt_en), .position_lock_o(lock), .jog_speed_o(jog),
      .jog_fwd_o(jfwd), .jog_rev_o(jrev), .seq_func_o(func));
   host_ctrl_model u_host_ctrl_model (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .func_on_i(func_on), .go_i(go),
      .count_i(cnt), .dir_i(dir), .seq_input_n_o(seq_n), .ref_pulse_o(pulse),
      .ref_dir_o(pdir), .busy_o(busy));
   task automatic results();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [9:0] a, output logic [31:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic pulses(input logic [7:0] n, input logic d, input logic [31:0] exp);
      @(posedge ref_clk_i);
      go <= 1'b1;
      cnt <= n;
      dir <= d;
      @(posedge ref_clk_i);
      go <= 1'b0;
      #1;
      for (int i = 0; i < 200 && busy; i++) wait_cyc(1);
      if (busy) begin
         n_errors++;
         results();
      end
      wait_cyc(6);
      rd_reg(OFS_MON_POSITION, v);
      chk("position", v, exp);
   endtask
   function automatic logic [9:0] exp_lim(input logic [1:0] u, input logic [3:0] m,
      input logic req, input logic [9:0] set, input int a, input int g);
      int pct;
      pct = (a < 0 ? -a : a) * 10 / g;
      if (pct > 100) pct = 100;
      if (m != CM_TORQUE && (u == USE_EXT_LIMIT || (u == USE_GATED_LIMIT && req)) && pct < set)
         return 10'(pct);
      return set;
   endfunction
   function automatic logic [6:0] exp_func(input logic [3:0] m, input logic [6:0] pn);
      logic [6:0] f;
      logic [3:0] c;
      for (int k = 0; k < 7; k++) begin
         c = ralloc[4*k +: 4];
         f[k] = !rmode ? !pn[k] : c < 7 ? !pn[c] : c == 7 ? 1'b1 : c == 8 ? 1'b0 : pn[c-9];
      end
      if (!rmode && m == CM_POS_INHIBIT) f[1] = 1'b0;
      return f;
   endfunction
   task automatic run_case(input logic [1:0] u, input logic [3:0] m, input int g,
      input logic [9:0] fs, input logic [9:0] rs, input int a, input logic [6:0] fn);
      logic [6:0] ef;
      logic       inh;
      wr_reg(OFS_REF_USE, 32'(u));
      wr_reg(OFS_CTRL_METHOD, 32'(m));
      wr_reg(OFS_LIMIT_GAIN, 32'(g));
      wr_reg(OFS_FWD_LIMIT, 32'(fs));
      wr_reg(OFS_REV_LIMIT, 32'(rs));
      analog <= 16'(a);
      func_on <= fn;
      wait_cyc(8);
      ef = exp_func(m, ~fn);
      inh = m == CM_POS_INHIBIT && (rmode ? ef[1] : fn[1]);
      chk("seq_func", 32'(func), 32'(ef));
      chk("fwd_limit", 32'(fwd), 32'(exp_lim(u, m, ef[5], fs, a, g)));
      chk("rev_limit", 32'(rev), 32'(exp_lim(u, m, ef[6], rs, a, g)));
      chk("ff_enable", 32'(ff), 32'(u == USE_FEED_FWD && m != CM_TORQUE));
      chk("tref_enable", 32'(tref), 32'(m == CM_TORQUE));
      if (m != CM_TORQUE) chk("lock", 32'({lock, cnt_en}), 32'({inh, !inh}));
   endtask
   initial begin
      repeat (10) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      wait_cyc(2);
      chk("reset_out", 32'({fwd, jog}), 32'({10'd100, 14'd500}));
      chk("reset_rev", 32'(rev), 32'd100);
      for (int i = 0; i < 10; i++) begin
         rd_reg(ofs[i], v);
         chk("reset_reg", v, rv[i]);
         if (i < 8) wr_reg(ofs[i], bad[i]);
         if (i < 8) rd_reg(ofs[i], v);
         if (i < 8) chk("refused", v, rv[i]);
      end
      run_case(1, 0, 30, 800, 800, 300, 0);
      run_case(1, 0, 30, 800, 800, -300, 0);
      run_case(3, 0, 10, 40, 800, -150, 7'h20);
      run_case(3, 1, 100, 0, 800, 599, 7'h60);
      run_case(0, CM_POS_INHIBIT, 30, 100, 100, 0, 7'h02);
      pulses(5, 1'b0, 32'd0);
      run_case(0, CM_POS_NO_INHIBIT, 30, 100, 100, 0, 7'h02);
      pulses(5, 1'b0, 32'd5);
      run_case(0, CM_POS_INHIBIT, 30, 100, 100, 0, 7'h00);
      pulses(3, 1'b1, 32'd2);
      wr_reg(OFS_JOG_RATE, 32'd10000);
      wait_cyc(3);
      chk("jog_cap", 32'(jog), 32'(MAX_RPM));
      wr_reg(OFS_JOG_CMD, 32'h1);
      wait_cyc(3);
      chk("jog_cmd", 32'({jrev, jfwd}), 32'h1);
      for (int i = 0; i < 40; i++) begin
         if (i == 30) wr_reg(OFS_ALLOCATION, 32'h6593217);
         if (i == 30) wr_reg(OFS_ROUTING_MODE, 32'h1);
         if (i == 30) {rmode, ralloc} = {1'b1, 28'h6593217};
         run_case(2'($random(seed)), ms[2'($random(seed))], 10 + $unsigned($random(seed)) % 91,
            10'($unsigned($random(seed)) % 801), 10'($unsigned($random(seed)) % 801),
            $random(seed) % 600, 7'($random(seed)));
      end
      results();
   end
endmodule
`default_nettype wire
